/* hw/ptd_pkg.sv */
// Contract
// - register at banked 03h and linear 003h
// - stop-mode recovery leaves register contents unchanged
// - bit 6 drives pin unless timer-one owns
// - bit 5 drives pin unless timer-two owns
// - bit 4 blocked by comparator or timer-zero
// - writes to bits 3..0 ignored
// - bit 3 pin, or stop-recovery status inverted
// - bit 2 pin or comparator-two output
// - bit 1 pin, comparator-one or amplifier
// - bit 0 pin, or one in analog
// - amplifier enable replaces comparator one
// - analog select turns low pins analog
package ptd_pkg;
   localparam logic [7:0] PTD_BANK_ADDR   = 8'h03;
   localparam logic [11:0] PTD_LINEAR_ADDR = 12'h003;
   localparam logic [3:0] PTD_OUT_RESET   = 4'h0;
   localparam logic [1:0] PTD_T1_COMBINED = 2'h1;
   localparam int PTD_BANK_MAX = 3;

   // one-hot address window selecting how the bus address is decoded
   typedef enum logic [1:0] {
      PTD_MODE_BANKED = 2'b01,
      PTD_MODE_LINEAR = 2'b10
   } ptd_amode_t;

   // select signals taken over from neighbouring control registers
   typedef struct packed {
      logic [1:0] timerOneMode;   // timer_one_control[7:6]
      logic       timerTwoOut;    // timer_two_control[0]
      logic       timerZeroOut;   // timer_zero_control[0]
      logic       compTwoOut;     // comparator_control[0]
      logic       ampEnable;      // port_mode_select[2]
      logic       analogMode;     // port_mode_select[1]
      logic       stopRecFour;    // stop_recovery_four[4]
   } ptd_sel_t;

   // alternate-function sources for the pins and read bits
   typedef struct packed {
      logic timerCombined;
      logic timerSixteen;
      logic timerEight;
      logic compOne;
      logic compTwo;
      logic irAmp;
      logic stopCond;
   } ptd_alt_t;
endpackage

/* hw/ptd_port_three.sv */
`timescale 1ns/1ps
// port three data register: output latch for pins 7..4, status readback
module ptd_port_three #(
   parameter int ADDR_W = 12
) (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic [ADDR_W-1:0] busAddr,
   input  wire logic              linearAccess,
   input  wire logic [7:0]        busWdata,
   input  wire logic              busWrite,
   input  wire logic              busRead,
   output logic      [7:0]        busRdata,
   input  wire ptd_pkg::ptd_sel_t selIn,
   input  wire ptd_pkg::ptd_alt_t altIn,
   input  wire logic [3:0]        pinIn,
   input  wire logic              stopRecovery,
   output logic      [3:0]        pinOut
);
   import ptd_pkg::*;

   logic [3:0]   outLatch_reg;
   logic [3:0]   outLatch_next;
   logic [3:0]   pinOut_next;
   logic [3:0]   pinSync;
   logic [3:0]   lowNibble;
   logic [7:0]   analogSync;
   logic         hit;
   ptd_amode_t   amode;
   ptd_sel_t     sel;
   ptd_alt_t     alt;

   // pins cross in through two flops before any logic looks at them
   ptd_sync #(
      .WIDTH(4)
   ) u_pin_sync (
      .clk     (clk),
      .resetn  (resetn),
      .asyncIn (pinIn),
      .syncOut (pinSync)
   );

   // analog comparator and amplifier outputs are asynchronous too
   ptd_sync #(
      .WIDTH(8)
   ) u_alt_sync (
      .clk     (clk),
      .resetn  (resetn),
      .asyncIn ({altIn.compOne, altIn.compTwo, altIn.irAmp, altIn.stopCond,
                 altIn.timerCombined, altIn.timerSixteen, altIn.timerEight, 1'b0}),
      .syncOut (analogSync)
   );

   // selects come from same-clock registers and need no synchroniser
   assign sel = selIn;
   always_comb begin
      alt               = altIn;
      alt.compOne       = analogSync[7];
      alt.compTwo       = analogSync[6];
      alt.irAmp         = analogSync[5];
      alt.stopCond      = analogSync[4];
      alt.timerCombined = analogSync[3];
      alt.timerSixteen  = analogSync[2];
      alt.timerEight    = analogSync[1];
   end

   // address decode: banked window in banks 0..3, or the linear address
   assign amode = linearAccess ? PTD_MODE_LINEAR : PTD_MODE_BANKED;
   always_comb begin
      case (amode)
         PTD_MODE_BANKED: hit = (busAddr[7:0] == PTD_BANK_ADDR) &&
                                (int'(busAddr[ADDR_W-1:8]) <= PTD_BANK_MAX);
         PTD_MODE_LINEAR: hit = (busAddr == PTD_LINEAR_ADDR);
         default:         hit = 1'b0;
      endcase
   end

   // the latch keeps its value across stop recovery; only resetn clears it
   always_comb begin
      outLatch_next = outLatch_reg;
      if (busWrite && hit) begin
         outLatch_next = busWdata[7:4];  // bits 3..0 dropped
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         outLatch_reg <= PTD_OUT_RESET;
      end else begin
         outLatch_reg <= outLatch_next;  // stopRecovery deliberately unused here
      end
   end

   // pin drive: alternate functions override, latch still holds the write
   always_comb begin
      pinOut_next[3] = outLatch_reg[3];
      pinOut_next[2] = (sel.timerOneMode == PTD_T1_COMBINED) ?
                       alt.timerCombined : outLatch_reg[2];
      pinOut_next[1] = sel.timerTwoOut ? alt.timerSixteen : outLatch_reg[1];
      if (sel.compTwoOut) begin
         pinOut_next[0] = alt.compTwo;
      end else if (sel.timerZeroOut) begin
         pinOut_next[0] = alt.timerEight;
      end else begin
         pinOut_next[0] = outLatch_reg[0];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pinOut <= PTD_OUT_RESET;
      end else begin
         pinOut <= pinOut_next;
      end
   end

   ptd_read_mux u_read_mux (
      .analogMode  (sel.analogMode),
      .ampEnable   (sel.ampEnable),
      .stopRecFour (sel.stopRecFour),
      .pinLevel    (pinSync),
      .compOne     (alt.compOne),
      .compTwo     (alt.compTwo),
      .irAmp       (alt.irAmp),
      .stopCond    (alt.stopCond),
      .lowNibble   (lowNibble)
   );

   // read data valid the cycle after the strobe; zero otherwise
   always_ff @(posedge clk) begin
      if (!resetn) begin
         busRdata <= 8'h00;
      end else if (busRead && hit) begin
         busRdata <= {outLatch_reg, lowNibble};  // last written value
      end else begin
         busRdata <= 8'h00;
      end
   end
endmodule

/* hw/ptd_read_mux.sv */
`timescale 1ns/1ps
// selects the low nibble of the readback from pins or analog status
module ptd_read_mux
   import ptd_pkg::*;
(
   input  wire logic             analogMode,
   input  wire logic             ampEnable,
   input  wire logic             stopRecFour,
   input  wire logic [3:0]       pinLevel,
   input  wire logic             compOne,
   input  wire logic             compTwo,
   input  wire logic             irAmp,
   input  wire logic             stopCond,
   output logic      [3:0]       lowNibble
);
   // bits 3..1 choose between digital pin and analog source, bit 0 between pin and a constant one
   always_comb begin
      if (analogMode || stopRecFour) begin
         lowNibble[3] = ~stopCond;                    // 0 means condition present
      end else begin
         lowNibble[3] = pinLevel[3];
      end
      lowNibble[2] = analogMode ? compTwo : pinLevel[2];
      case ({ampEnable, analogMode})
         2'b00:   lowNibble[1] = pinLevel[1];
         2'b01:   lowNibble[1] = compOne;
         default: lowNibble[1] = irAmp;
      endcase
      lowNibble[0] = analogMode ? 1'b1 : pinLevel[0];
   end
endmodule

/* hw/ptd_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser, one per bit
module ptd_sync #(
   parameter int WIDTH = 4
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stageOne_reg;

   // first stage feeds only the second
   always_ff @(posedge clk) begin
      if (!resetn) begin
         stageOne_reg <= '0;
         syncOut      <= '0;
      end else begin
         stageOne_reg <= asyncIn;
         syncOut      <= stageOne_reg;
      end
   end
endmodule

/* test/ptd_chk.sv */
`timescale 1ns/1ps
// port-level checks of the port three register
module ptd_chk #(
   parameter int ADDR_W = 12
) (
   input wire logic              clk,
   input wire logic              resetn,
   input wire logic [ADDR_W-1:0] busAddr,
   input wire logic              linearAccess,
   input wire logic [7:0]        busWdata,
   input wire logic              busWrite,
   input wire logic              busRead,
   input wire logic [7:0]        busRdata,
   input wire ptd_pkg::ptd_sel_t selIn,
   input wire ptd_pkg::ptd_alt_t altIn,
   input wire logic              stopRecovery,
   input wire logic [3:0]        pinOut
);
   import ptd_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic hit;
   // banks 0..3 at 03h, or linear 003h only
   assign hit = linearAccess ? (busAddr == 12'h003) : (busAddr[7:0] == 8'h03 && busAddr[11:8] <= 4'h3);
   sequence s_wr; busWrite && hit; endsequence
   sequence s_rd; busRead && hit; endsequence
   // alternate sources reach a pin three edges later, so the select must hold four
   a_rdata_idle_zero: assert property (!(busRead && hit) |=> busRdata == 8'h00) else $error("stray read data");
   a_latch_read_back: assert property (s_wr ##1 s_rd |=> busRdata[7:4] == $past(busWdata[7:4], 2))
      else $error("readback differs");
   a_pin_seven_out: assert property (s_wr |-> ##2 pinOut[3] == $past(busWdata[7], 2)) else $error("pin seven");
   a_stop_keeps_pin: assert property (stopRecovery && !$past(busWrite) |=> $stable(pinOut[3]))
      else $error("stop recovery moved pin");
   a_pin_six_timer: assert property ((selIn.timerOneMode == 2'h1) [*4] |-> pinOut[2] == $past(altIn.timerCombined, 3))
      else $error("pin six override");
   a_pin_five_timer: assert property (selIn.timerTwoOut [*4] |-> pinOut[1] == $past(altIn.timerSixteen, 3))
      else $error("pin five override");
   a_pin_four_comp: assert property (selIn.compTwoOut [*4] |-> pinOut[0] == $past(altIn.compTwo, 3))
      else $error("pin four override");
   a_bit_zero_one: assert property (busRead && hit && selIn.analogMode |=> busRdata[0])
      else $error("bit zero not one");
endmodule

bind ptd_port_three ptd_chk #(.ADDR_W(ADDR_W)) i_ptd_chk (.clk(clk), .resetn(resetn), .busAddr(busAddr),
   .linearAccess(linearAccess), .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead), .busRdata(busRdata),
   .selIn(selIn), .altIn(altIn), .stopRecovery(stopRecovery), .pinOut(pinOut));

/* test/ptd_far_side.sv */
`timescale 1ns/1ps
// pins and analog sources; levels move on a clock edge, through nonblocking assignments
module ptd_far_side (
   input  wire logic              clk,
   input  wire logic [3:0]        pinSet,
   input  wire ptd_pkg::ptd_alt_t altSet,
   output logic      [3:0]        pinIn = 4'h0,
   output ptd_pkg::ptd_alt_t      altIn = '0
);
   import ptd_pkg::*;
   // requested levels appear one edge later, like a slow pad
   always @(posedge clk) begin
      pinIn <= pinSet;
      altIn <= altSet;
   end
endmodule

/* test/tb_port_three_data_register.sv */
`timescale 1ns/1ps
module tb_port_three_data_register;
   import ptd_pkg::*;
   logic        clk = 1'b0, resetn = 1'b0, linearAccess = 1'b0, busWrite = 1'b0, busRead = 1'b0;
   logic        stopRecovery = 1'b0;
   logic [11:0] busAddr = 12'h000;
   logic [7:0]  busWdata = 8'h00, busRdata;
   logic [3:0]  pinIn, pinOut, low, pinSet = 4'hA;
   ptd_sel_t    selIn = '0;
   ptd_alt_t    altIn, altSet = '0;
   int          errorCnt = 0, comparisons = 0;
   ptd_port_three i_ptd_port_three (.clk(clk), .resetn(resetn), .busAddr(busAddr), .linearAccess(linearAccess),
      .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead), .busRdata(busRdata), .selIn(selIn),
      .altIn(altIn), .pinIn(pinIn), .stopRecovery(stopRecovery), .pinOut(pinOut));
   ptd_far_side i_ptd_far_side (.clk(clk), .pinSet(pinSet), .altSet(altSet), .pinIn(pinIn), .altIn(altIn));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         errorCnt++;
         $display("Error %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic completeRun();
      $display("mismatches %0d, compares %0d", errorCnt, comparisons);
      if (errorCnt == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // raises one strobe; the next call or idle() ends it, so accesses can run back to back
   task automatic acc(input logic we, input logic [11:0] a, input logic lin, input logic [7:0] d);
      @(posedge clk);
      busAddr <= a;
      linearAccess <= lin;
      busWdata <= d;
      busWrite <= we;
      busRead <= !we;
   endtask
   task automatic idle();
      @(posedge clk);
      busWrite <= 1'b0;
      busRead <= 1'b0;
      #1;
   endtask
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask
   // no handshake to wait on, but a hang still ends the run
   initial begin
      repeat (5000) @(posedge clk);
      errorCnt++;
      completeRun();
   end
   initial begin
      int i;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      acc(1'b0, 12'h003, 1'b0, 8'h00);
      idle();
      check(busRdata, 8'h0A);
      check({4'h0, pinOut}, 8'h00);
      acc(1'b1, 12'h303, 1'b0, 8'hF5);
      acc(1'b0, 12'h103, 1'b0, 8'h00);
      idle();
      check(busRdata, 8'hFA);
      check({4'h0, pinOut}, 8'h0F);
      acc(1'b1, 12'h003, 1'b1, 8'h50);
      acc(1'b1, 12'h103, 1'b1, 8'hFF);
      acc(1'b1, 12'h403, 1'b0, 8'hFF);
      acc(1'b0, 12'h403, 1'b0, 8'h00);
      idle();
      check(busRdata, 8'h00);
      @(posedge clk);
      stopRecovery <= 1'b1;
      @(posedge clk);
      stopRecovery <= 1'b0;
      acc(1'b0, 12'h003, 1'b1, 8'h00);
      idle();
      check(busRdata, 8'h5A);
      check({4'h0, pinOut}, 8'h05);
      selIn <= 8'h68;
      altSet <= 7'h30;
      settle();
      check({4'h0, pinOut}, 8'h02);
      acc(1'b1, 12'h003, 1'b0, 8'hF0);
      idle();
      acc(1'b0, 12'h003, 1'b0, 8'h00);
      idle();
      check(busRdata, 8'hFA);
      check({4'h0, pinOut}, 8'h0A);
      // timer-one field at 10 must not take pin six over; timer zero owns pin four
      selIn <= 8'h90;
      altSet <= 7'h00;
      settle();
      check({4'h0, pinOut}, 8'h0E);
      // every amp, analog and stop-status combination, pins held at A;
      // two source sets, so every analog source differs from the pin level it replaces in one of them
      for (i = 0; i < 16; i++) begin
         selIn <= {5'h00, i[2:0]};
         altSet <= i[3] ? 7'h02 : 7'h0D;
         settle();
         low[3] = (i[1] || i[0]) ? i[3] : pinSet[3];
         low[2] = i[1] ? !i[3] : pinSet[2];
         low[1] = i[2] ? i[3] : (i[1] ? !i[3] : pinSet[1]);
         low[0] = i[1] ? 1'b1 : pinSet[0];
         acc(1'b0, 12'h203, 1'b0, 8'h00);
         idle();
         check(busRdata, {4'hF, low});
      end
      completeRun();
   end
endmodule
